// *** rms_pkg.sv ***
package rms_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_SQ_START = 8'h04;
    localparam logic [7:0] A_SQ_ESTOP = 8'h08;
    localparam logic [7:0] A_SQ_SETUP = 8'h0c;
    localparam logic [7:0] A_TMO = 8'h10;
    localparam logic [7:0] A_ILK_A = 8'h14;
    localparam logic [7:0] A_ILK_B = 8'h18;
    localparam logic [7:0] A_STATUS = 8'h1c;
    localparam logic [7:0] A_FW = 8'h20;
    localparam logic [7:0] A_CFG_VER = 8'h24;
    localparam logic [7:0] A_DL_DATE = 8'h28;
    localparam logic [7:0] A_APP_CHAR = 8'h2c;
    localparam logic [7:0] A_APP_IDX = 8'h30;
    localparam logic [3:0] SEL_ALL = 4'hf;

    // ------------------------------------------------------------
    // Buttons, sequences, timing
    // ------------------------------------------------------------
    localparam logic [3:0] BTN_NONE = 4'h0;
    localparam logic [3:0] BTN_SEQ_LO = 4'h1;
    localparam logic [3:0] BTN_SEQ_HI = 4'h6;
    localparam logic [3:0] BTN_TRIG = 4'h7;
    localparam logic [2:0] SEQ_MAX = 3'h6;
    localparam logic [15:0] BTN_VALID = 16'hfffe;
    localparam logic [15:0] BTN_REDUCED = 16'hf000;
    localparam logic [5:0] SB_MIN = 6'h01;
    localparam logic [5:0] SB_MAX = 6'h3c;
    localparam logic [8:0] PS_MIN = 9'h001;
    localparam logic [8:0] PS_MAX = 9'h12c;
    localparam logic [8:0] IDLE_MAX = 9'h1ff;
    localparam int APP_LEN = 30;
    localparam logic [4:0] APP_IDX_MAX = 5'h1d;
    localparam longint CLK_HZ = 125000000;
    localparam longint MINUTE_S = 60;
    localparam longint MIN_CYC = MINUTE_S * CLK_HZ;

    typedef enum logic [2:0] {M_STOP, M_START, M_SETUP, M_ESTOP, M_OFF} rms_mode_t;

    typedef struct packed {
        logic reduced;
        logic both_bases;
        logic multi_base_control;
        logic fall_en;
        logic psave_en;
        logic standby_en;
        logic setup_en;
        logic estop_en;
        logic start_en;
    } rms_ctrl_t;

    typedef struct packed {
        logic [5:0][2:0] step;
        logic [2:0] len;
    } rms_seq_t;

    typedef struct packed {
        logic [8:0] psave;
        logic [5:0] standby;
    } rms_tmo_t;

    typedef struct packed {
        logic [7:0] major;
        logic [7:0] minor;
        logic [7:0] quality;
        logic [7:0] internal;
    } rms_fw_t;

    typedef logic [3:0][7:0] rms_ilk_t;

    localparam rms_tmo_t TMO_RST = '{psave: 9'h00f, standby: 6'h0f};
    localparam rms_ilk_t ILK_RST = 32'h0000_0012;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } rms_wb_req_t;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } rms_wb_rsp_t;
endpackage

// *** rms_sequencer.sv ***
`timescale 1ns/1ps
module rms_sequencer #(
    parameter logic [32:0] MIN_CYC = 33'(rms_pkg::MIN_CYC),
    parameter rms_pkg::rms_fw_t FW_VER = 32'h0100_0000
) (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire rms_pkg::rms_wb_req_t wb_req,
    output rms_pkg::rms_wb_rsp_t wb_rsp,
    input wire logic [15:0] btn,
    input wire logic estop,
    input wire logic setup_key,
    input wire logic fall_detect,
    output rms_pkg::rms_mode_t mode,
    output logic power_off,
    output logic [15:0] motion,
    output logic id_store
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        rms_pkg::rms_mode_t mode;
        logic [2:0] st_idx;
        logic [2:0] es_idx;
        logic [2:0] su_idx;
        logic [15:0] btn_q;
        logic key_q;
        logic [32:0] tick;
        logic [8:0] idle;
        logic by_sb;
        rms_pkg::rms_ctrl_t ctrl;
        rms_pkg::rms_seq_t sq_start;
        rms_pkg::rms_seq_t sq_estop;
        rms_pkg::rms_seq_t sq_setup;
        rms_pkg::rms_tmo_t tmo;
        rms_pkg::rms_ilk_t ilk_a;
        rms_pkg::rms_ilk_t ilk_b;
        logic [31:0] cfg_ver;
        logic [31:0] dl_date;
        logic [29:0][7:0] app;
        logic [4:0] app_idx;
        logic ack;
        logic [31:0] dat;
        logic [15:0] motion;
        logic id_store;
    } rms_st_t;

    rms_st_t st;
    rms_st_t next_st;

    function automatic logic [3:0] first_btn(input logic [15:0] v);
        logic [3:0] r;
        r = rms_pkg::BTN_NONE;
        for (int i = 15; i >= 1; i--) begin
            if (v[i]) begin
                r = 4'(i);
            end
        end
        return r;
    endfunction

    function automatic logic is_step(input logic [3:0] b);
        return b >= rms_pkg::BTN_SEQ_LO && b <= rms_pkg::BTN_SEQ_HI;
    endfunction

    // Mismatch restarts; a press equal to step one counts as new step one
    function automatic logic [2:0] seq_adv(
        input logic [2:0] idx,
        input rms_pkg::rms_seq_t s,
        input logic [3:0] b
    );
        logic [2:0] r;
        r = idx;
        if (is_step(b)) begin
            if (idx < s.len && {1'b0, s.step[idx]} == b) begin
                r = idx + 3'h1;
            end else if (s.len != 3'h0 && {1'b0, s.step[0]} == b) begin
                r = 3'h1;
            end else begin
                r = 3'h0;
            end
        end
        return r;
    endfunction

    function automatic rms_pkg::rms_seq_t seq_wr(input logic [31:0] d);
        rms_pkg::rms_seq_t s;
        s = rms_pkg::rms_seq_t'(d[20:0]);
        if (s.len > rms_pkg::SEQ_MAX) begin
            s.len = rms_pkg::SEQ_MAX;
        end
        return s;
    endfunction

    // ------------------------------------------------------------
    // Press decode
    // ------------------------------------------------------------
    logic [15:0] vmask;
    logic [3:0] pb;
    logic pressed;
    logic tick;
    logic use_b;
    logic start_seq;
    logic estop_seq;
    logic setup_seq;
    logic [2:0] st_n;
    logic [2:0] es_n;
    logic [2:0] su_n;

    assign vmask = st.ctrl.reduced ? (rms_pkg::BTN_VALID & ~rms_pkg::BTN_REDUCED)
                                   : rms_pkg::BTN_VALID;
    assign pb = first_btn(btn & ~st.btn_q & vmask);
    assign pressed = pb != rms_pkg::BTN_NONE;
    assign tick = st.tick == MIN_CYC - 33'h1;
    assign use_b = st.ctrl.multi_base_control && st.ctrl.both_bases;
    assign start_seq = st.ctrl.start_en && st.sq_start.len != 3'h0;
    assign estop_seq = st.ctrl.estop_en && st.sq_estop.len != 3'h0;
    assign setup_seq = st.ctrl.setup_en && st.sq_setup.len != 3'h0;
    assign st_n = seq_adv(st.st_idx, st.sq_start, pb);
    assign es_n = seq_adv(st.es_idx, st.sq_estop, pb);
    assign su_n = seq_adv(st.su_idx, st.sq_setup, pb);

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    logic key_rise;
    logic go_start;
    logic go_setup;
    logic rst_ok;
    logic [15:0] act;
    logic [15:0] blk;
    rms_pkg::rms_ilk_t tbl;
    logic [3:0] ia;
    logic [3:0] ib;

    always_comb begin
        next_st = st;
        key_rise = setup_key && !st.key_q;
        go_start = start_seq ? (is_step(pb) && st_n == st.sq_start.len)
                             : pb == rms_pkg::BTN_TRIG;
        go_setup = setup_seq ? (is_step(pb) && su_n == st.sq_setup.len)
                             : key_rise;
        // Trigger only counts once the steps are all in
        rst_ok = pb == rms_pkg::BTN_TRIG
                 && (!estop_seq || st.es_idx == st.sq_estop.len);
        next_st.btn_q = btn;
        next_st.key_q = setup_key;
        next_st.st_idx = st_n;
        next_st.es_idx = es_n;
        next_st.su_idx = su_n;
        next_st.ack = 1'b0;
        next_st.id_store = 1'b0;
        next_st.tick = tick ? 33'h0 : st.tick + 33'h1;
        if (tick && st.idle != rms_pkg::IDLE_MAX) begin
            next_st.idle = st.idle + 9'h1;
        end

        case (st.mode)
            rms_pkg::M_STOP: begin
                if (st.ctrl.psave_en && st.by_sb
                        && st.idle >= st.tmo.psave) begin
                    next_st.mode = rms_pkg::M_OFF;
                end else if (go_setup) begin
                    next_st.mode = rms_pkg::M_SETUP;
                end else if (go_start) begin
                    next_st.mode = rms_pkg::M_START;
                end
            end
            rms_pkg::M_START: begin
                if (st.ctrl.standby_en && !pressed
                        && st.idle >= 9'(st.tmo.standby)) begin
                    next_st.mode = rms_pkg::M_STOP;
                    next_st.by_sb = 1'b1;
                end
            end
            rms_pkg::M_SETUP: begin
                if (key_rise) begin
                    next_st.mode = rms_pkg::M_STOP;
                end
            end
            rms_pkg::M_ESTOP: begin
                if (rst_ok && !estop) begin
                    next_st.mode = rms_pkg::M_STOP;
                end
            end
            rms_pkg::M_OFF: begin
                next_st.mode = rms_pkg::M_OFF;
            end
            default: begin
                next_st.mode = rms_pkg::M_ESTOP;
            end
        endcase

        // Safety paths override any sequence progress
        if (estop && st.mode != rms_pkg::M_OFF) begin
            next_st.mode = rms_pkg::M_ESTOP;
        end
        if (st.ctrl.fall_en && fall_detect) begin
            next_st.mode = rms_pkg::M_OFF;
        end

        if (next_st.mode != st.mode) begin
            next_st.st_idx = 3'h0;
            next_st.es_idx = 3'h0;
            next_st.su_idx = 3'h0;
            if (next_st.mode != rms_pkg::M_STOP) begin
                next_st.by_sb = 1'b0;
            end
        end
        if (pressed || next_st.mode != st.mode) begin
            next_st.idle = 9'h0;
            next_st.tick = 33'h0;
        end

        // Interlock: both members of a live pair drop out
        act = (st.mode == rms_pkg::M_START) ? (btn & vmask) : 16'h0;
        tbl = use_b ? st.ilk_b : st.ilk_a;
        blk = 16'h0;
        ia = 4'h0;
        ib = 4'h0;
        for (int i = 0; i < 4; i++) begin
            ia = tbl[i][7:4];
            ib = tbl[i][3:0];
            if (ia != 4'h0 && ib != 4'h0 && act[ia] && act[ib]) begin
                blk[ia] = 1'b1;
                blk[ib] = 1'b1;
            end
        end
        next_st.motion = act & ~blk;

        // --------------------------------------------------------
        // Wishbone slave, one wait state
        // --------------------------------------------------------
        if (wb_req.cyc && wb_req.stb && !st.ack) begin
            next_st.ack = 1'b1;
            case (wb_req.adr)
                rms_pkg::A_CTRL: next_st.dat = 32'(st.ctrl);
                rms_pkg::A_SQ_START: next_st.dat = 32'(st.sq_start);
                rms_pkg::A_SQ_ESTOP: next_st.dat = 32'(st.sq_estop);
                rms_pkg::A_SQ_SETUP: next_st.dat = 32'(st.sq_setup);
                rms_pkg::A_TMO: next_st.dat = 32'(st.tmo);
                rms_pkg::A_ILK_A: next_st.dat = st.ilk_a;
                rms_pkg::A_ILK_B: next_st.dat = st.ilk_b;
                rms_pkg::A_STATUS: next_st.dat = 32'({st.by_sb, st.mode,
                    st.st_idx, st.es_idx, st.su_idx, st.idle});
                rms_pkg::A_FW: next_st.dat = FW_VER;
                rms_pkg::A_CFG_VER: next_st.dat = st.cfg_ver;
                rms_pkg::A_DL_DATE: next_st.dat = st.dl_date;
                rms_pkg::A_APP_CHAR: next_st.dat = 32'(st.app[st.app_idx]);
                rms_pkg::A_APP_IDX: next_st.dat = 32'(st.app_idx);
                default: next_st.dat = 32'h0;
            endcase
            // Partial byte writes are ignored; most fields span lanes, A_APP_CHAR and A_APP_IDX fit in lane 0
            if (wb_req.we && wb_req.sel == rms_pkg::SEL_ALL) begin
                case (wb_req.adr)
                    rms_pkg::A_CTRL: next_st.ctrl = rms_pkg::rms_ctrl_t'(wb_req.dat[8:0]);
                    rms_pkg::A_SQ_START: next_st.sq_start = seq_wr(wb_req.dat);
                    rms_pkg::A_SQ_ESTOP: next_st.sq_estop = seq_wr(wb_req.dat);
                    rms_pkg::A_SQ_SETUP: next_st.sq_setup = seq_wr(wb_req.dat);
                    rms_pkg::A_TMO: begin
                        next_st.tmo = rms_pkg::rms_tmo_t'(wb_req.dat[14:0]);
                        if (next_st.tmo.standby < rms_pkg::SB_MIN) begin
                            next_st.tmo.standby = rms_pkg::SB_MIN;
                        end else if (next_st.tmo.standby > rms_pkg::SB_MAX) begin
                            next_st.tmo.standby = rms_pkg::SB_MAX;
                        end
                        if (next_st.tmo.psave < rms_pkg::PS_MIN) begin
                            next_st.tmo.psave = rms_pkg::PS_MIN;
                        end else if (next_st.tmo.psave > rms_pkg::PS_MAX) begin
                            next_st.tmo.psave = rms_pkg::PS_MAX;
                        end
                    end
                    rms_pkg::A_ILK_A: next_st.ilk_a = wb_req.dat;
                    rms_pkg::A_ILK_B: next_st.ilk_b = wb_req.dat;
                    rms_pkg::A_CFG_VER: begin
                        next_st.cfg_ver = wb_req.dat;
                        next_st.id_store = 1'b1;
                    end
                    rms_pkg::A_DL_DATE: begin
                        next_st.dl_date = wb_req.dat;
                        next_st.id_store = 1'b1;
                    end
                    rms_pkg::A_APP_CHAR: begin
                        // Oldest character falls off the far end
                        next_st.app = {st.app[28:0], wb_req.dat[7:0]};
                        next_st.id_store = 1'b1;
                    end
                    rms_pkg::A_APP_IDX: begin
                        next_st.app_idx = wb_req.dat[4:0] > rms_pkg::APP_IDX_MAX
                            ? rms_pkg::APP_IDX_MAX : wb_req.dat[4:0];
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st <= '0;
            st.mode <= rms_pkg::M_ESTOP;
            st.tmo <= rms_pkg::TMO_RST;
            st.ilk_a <= rms_pkg::ILK_RST;
            st.ilk_b <= rms_pkg::ILK_RST;
        end else begin
            st <= next_st;
        end
    end

    assign wb_rsp = '{ack: st.ack, dat: st.dat};
    assign mode = st.mode;
    assign power_off = st.mode == rms_pkg::M_OFF;
    assign motion = st.motion;
    assign id_store = st.id_store;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    property p_estop_latch;
        estop && st.mode != rms_pkg::M_OFF && !(st.ctrl.fall_en && fall_detect)
            |=> st.mode == rms_pkg::M_ESTOP;
    endproperty
    a_estop_latch: assert property (p_estop_latch)
        else $error("estop did not latch");

    property p_estop_hold;
        st.mode == rms_pkg::M_ESTOP && pb != rms_pkg::BTN_TRIG
            |=> st.mode inside {rms_pkg::M_ESTOP, rms_pkg::M_OFF};
    endproperty
    a_estop_hold: assert property (p_estop_hold)
        else $error("estop left without trigger");

    property p_trig_reset;
        st.mode == rms_pkg::M_ESTOP && !estop_seq && pb == rms_pkg::BTN_TRIG
            && !estop && !(st.ctrl.fall_en && fall_detect)
            |=> st.mode == rms_pkg::M_STOP;
    endproperty
    a_trig_reset: assert property (p_trig_reset)
        else $error("trigger did not reset");

    property p_seq_reset;
        st.mode == rms_pkg::M_ESTOP && estop_seq && st.es_idx != st.sq_estop.len
            |=> st.mode != rms_pkg::M_STOP;
    endproperty
    a_seq_reset: assert property (p_seq_reset)
        else $error("reset before sequence done");

    property p_start_gate;
        st.mode == rms_pkg::M_STOP && start_seq
            && !(is_step(pb) && st_n == st.sq_start.len)
            |=> st.mode != rms_pkg::M_START;
    endproperty
    a_start_gate: assert property (p_start_gate)
        else $error("start without sequence");

    property p_standby;
        st.mode == rms_pkg::M_START && st.ctrl.standby_en && !pressed && !estop
            && !(st.ctrl.fall_en && fall_detect)
            && st.idle >= 9'(st.tmo.standby)
            |=> st.mode == rms_pkg::M_STOP && st.by_sb;
    endproperty
    a_standby: assert property (p_standby)
        else $error("standby timeout missed");

    property p_fall;
        st.ctrl.fall_en && fall_detect |=> power_off ##1 power_off;
    endproperty
    a_fall: assert property (p_fall)
        else $error("fall did not power off");

    property p_ilock12;
        st.mode == rms_pkg::M_START && !use_b && st.ilk_a[0] == rms_pkg::ILK_RST[0]
            && btn[1] && btn[2] |=> !motion[1] && !motion[2];
    endproperty
    a_ilock12: assert property (p_ilock12)
        else $error("opposed buttons both driven");

    property p_reduced;
        st.ctrl.reduced |=> (motion & rms_pkg::BTN_REDUCED) == 16'h0;
    endproperty
    a_reduced: assert property (p_reduced)
        else $error("reduced button drove motion");

    property p_ack;
        wb_req.cyc && wb_req.stb && !wb_rsp.ack |=> wb_rsp.ack ##1 !wb_rsp.ack;
    endproperty
    a_ack: assert property (p_ack)
        else $error("bus ack timing wrong");
endmodule

// *** rms_operator.sv ***
`timescale 1ns/1ps
// ------------------------------------------------------------
// Operator buttons and paired base station
// ------------------------------------------------------------
module rms_operator (
    input wire logic ref_clk,
    input wire logic power_off,
    output logic [15:0] btn,
    output logic link_up
);
    initial begin
        btn = 16'h0000;
    end
    // Base drops the link and waits for the remote to come back up
    always @(posedge ref_clk) begin
        link_up <= power_off !== 1'b1;
    end
    // One press: a rising edge, then release so the next press is seen
    task automatic press(input int n);
        @(posedge ref_clk) btn <= 16'h0001 << n;
        @(posedge ref_clk) btn <= 16'h0000;
        @(posedge ref_clk);
    endtask
    task automatic hold(input logic [15:0] v);
        @(posedge ref_clk) btn <= v;
        repeat (3) @(posedge ref_clk);
    endtask
endmodule

// *** rms_sequencer_test.sv ***
`timescale 1ns/1ps
module rms_sequencer_test;
    localparam rms_pkg::rms_fw_t FW = 32'h0102_0304; // Arbitrary value
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    rms_pkg::rms_wb_req_t wb_req = '0;
    rms_pkg::rms_wb_rsp_t wb_rsp;
    logic estop = 1'b0;
    logic setup_key = 1'b0;
    logic fall_detect = 1'b0;
    rms_pkg::rms_mode_t mode;
    logic power_off;
    logic [15:0] motion;
    logic [15:0] btn;
    logic link_up;
    logic [31:0] rd;
    logic id_store;
    logic ids;
    logic [3:0] sel_n = rms_pkg::SEL_ALL;
    int failures = 0;
    int check_count = 0;

    initial begin
        forever #4 ref_clk = ~ref_clk;
    end
    // Short minute so the idle timers finish within the run
    rms_sequencer #(.MIN_CYC(33'h14), .FW_VER(FW)) i_dut (.ref_clk(ref_clk),
        .sys_rst(sys_rst), .wb_req(wb_req), .wb_rsp(wb_rsp), .btn(btn), .estop(estop),
        .setup_key(setup_key), .fall_detect(fall_detect), .mode(mode),
        .power_off(power_off), .motion(motion), .id_store(id_store));
    rms_operator i_ops (.ref_clk(ref_clk), .power_off(power_off), .btn(btn),
        .link_up(link_up));

    // ------------------------------------------------------------
    // Bus, checks and closing
    // ------------------------------------------------------------
    task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: sel_n, dat: d};
        do @(posedge ref_clk); while (wb_rsp.ack !== 1'b1);
        rd = wb_rsp.dat;
        ids = id_store;
        wb_req <= '0;
    endtask
    task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            $display("unexpected %s: expected %h, seen %h", what, e, g);
            failures++;
        end
    endtask
    task automatic chk_mode(input rms_pkg::rms_mode_t e, input int wait_n);
        repeat (wait_n) @(posedge ref_clk);
        chk("mode", 32'(e), 32'(mode));
    endtask
    task automatic do_reset;
        @(posedge ref_clk) sys_rst <= 1'b1;
        repeat (8) @(posedge ref_clk);
        sys_rst <= 1'b0;
    endtask
    task automatic end_sim;
        if (failures == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge ref_clk);
        failures++;
        end_sim;
    end

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        do_reset;
        chk_mode(rms_pkg::M_ESTOP, 2);
        i_ops.press(7);
        chk_mode(rms_pkg::M_STOP, 2);
        bus(1'b0, rms_pkg::A_FW, 32'h0);
        chk("fw", FW, rd);
        bus(1'b0, 8'hfc, 32'h0);
        chk("unmapped", 32'h0, rd);
        bus(1'b0, rms_pkg::A_TMO, 32'h0);
        chk("tmo", 32'h0000_03cf, rd);
        for (int i = 1; i <= 31; i++) bus(1'b1, rms_pkg::A_APP_CHAR, 32'(i));
        bus(1'b1, rms_pkg::A_APP_IDX, 32'h1d);
        bus(1'b0, rms_pkg::A_APP_CHAR, 32'h0);
        chk("app", 32'h2, rd);
        bus(1'b1, rms_pkg::A_APP_IDX, 32'h1f);
        bus(1'b0, rms_pkg::A_APP_IDX, 32'h0);
        chk("app_idx", 32'h1d, rd);
        // Identity words; a partial write is acked but dropped
        bus(1'b1, rms_pkg::A_CFG_VER, 32'h8765_4321);
        chk("id_store", 32'h1, 32'(ids));
        bus(1'b1, rms_pkg::A_DL_DATE, 32'h789a_bcde);
        sel_n = 4'h3;
        bus(1'b1, rms_pkg::A_CFG_VER, 32'h0);
        chk("id_store", 32'h0, 32'(ids));
        sel_n = rms_pkg::SEL_ALL;
        bus(1'b0, rms_pkg::A_CFG_VER, 32'h0);
        chk("cfg_ver", 32'h8765_4321, rd);
        bus(1'b0, rms_pkg::A_DL_DATE, 32'h0);
        chk("dl_date", 32'h789a_bcde, rd);
        // Interlocks in START
        i_ops.press(7);
        chk_mode(rms_pkg::M_START, 2);
        i_ops.hold(16'h0006);
        chk("motion", 32'h0, 32'(motion));
        i_ops.hold(16'h0002);
        chk("motion", 32'h2, 32'(motion));
        bus(1'b1, rms_pkg::A_CTRL, 32'h100);
        i_ops.hold(16'h1008);
        chk("motion", 32'h8, 32'(motion));
        i_ops.hold(16'hefe1);
        chk("motion", 32'h0fe0, 32'(motion));
        // Tool copies a primary edit into the second table only
        bus(1'b1, rms_pkg::A_ILK_A, 32'h12);
        bus(1'b1, rms_pkg::A_ILK_B, 32'h12);
        bus(1'b1, rms_pkg::A_ILK_B, 32'h34);
        bus(1'b0, rms_pkg::A_ILK_A, 32'h0);
        chk("ilk_a", 32'h12, rd);
        bus(1'b1, rms_pkg::A_CTRL, 32'h0c0);
        i_ops.hold(16'h0018);
        chk("motion", 32'h0, 32'(motion));
        i_ops.hold(16'h0006);
        chk("motion", 32'h6, 32'(motion));
        i_ops.hold(16'h0000);
        // Emergency stop and its reset sequence
        estop <= 1'b1;
        chk_mode(rms_pkg::M_ESTOP, 3);
        estop <= 1'b0;
        bus(1'b1, rms_pkg::A_SQ_ESTOP, 32'h11);
        bus(1'b1, rms_pkg::A_CTRL, 32'h2);
        i_ops.press(7);
        chk_mode(rms_pkg::M_ESTOP, 2);
        i_ops.press(2);
        bus(1'b0, rms_pkg::A_STATUS, 32'h0);
        chk("status", 32'h000c_1000, rd);
        i_ops.press(7);
        chk_mode(rms_pkg::M_STOP, 2);
        // Start sequence 1,1 with standby and power saving of one minute
        bus(1'b1, rms_pkg::A_SQ_START, 32'h4a);
        bus(1'b1, rms_pkg::A_TMO, 32'h41);
        bus(1'b1, rms_pkg::A_CTRL, 32'h19);
        i_ops.press(7);
        i_ops.press(1);
        chk_mode(rms_pkg::M_STOP, 2);
        i_ops.press(1);
        chk_mode(rms_pkg::M_START, 2);
        repeat (12) @(posedge ref_clk);
        i_ops.press(3);
        chk_mode(rms_pkg::M_START, 18);
        chk_mode(rms_pkg::M_STOP, 3);
        chk_mode(rms_pkg::M_STOP, 19);
        chk_mode(rms_pkg::M_OFF, 3);
        chk("power_off", 32'h1, 32'(power_off));
        // Setup sequence and fall detection
        do_reset;
        i_ops.press(7);
        bus(1'b1, rms_pkg::A_SQ_SETUP, 32'h19);
        bus(1'b1, rms_pkg::A_CTRL, 32'h4);
        i_ops.press(3);
        chk_mode(rms_pkg::M_SETUP, 2);
        @(posedge ref_clk) setup_key <= 1'b1;
        chk_mode(rms_pkg::M_STOP, 3);
        chk("link", 32'h1, 32'(link_up));
        bus(1'b1, rms_pkg::A_CTRL, 32'h20);
        @(posedge ref_clk) fall_detect <= 1'b1;
        chk_mode(rms_pkg::M_OFF, 3);
        chk("link", 32'h0, 32'(link_up));
        end_sim;
    end
endmodule
